// >>> core/sas_core.v
// stack pointers, flag stack and address-space access logic
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.vh"
module sas_core #(
    parameter NVM_SIZE = 16'h2000,
    parameter FLAG_DEPTH = 8,
    parameter FLAG_PTR_W = 3,
    parameter NVM_WAIT = 2
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire op_valid_i,
    input wire [3:0] op_code_i,
    input wire [7:0] op_dst_i,
    input wire [7:0] op_src_i,
    input wire [7:0] op_imm_i,
    input wire [15:0] pc_i,
    input wire [2:0] alu_flags_i,
    input wire alu_flags_we_i,
    input wire [7:0] mem_rdata_i,
    input wire [7:0] in_rdata_i,
    output reg op_done_o,
    output reg [15:0] pc_load_o,
    output reg pc_load_valid_o,
    output reg [15:0] mem_addr_o,
    output reg [7:0] mem_wdata_o,
    output reg mem_we_o,
    output reg mem_re_o,
    output reg [2:0] mem_region_o,
    output reg [3:0] mem_wait_o,
    output reg opt_unimpl_o,
    output reg [7:0] in_addr_o,
    output reg in_re_o,
    output reg [7:0] out_addr_o,
    output reg [7:0] out_wdata_o,
    output reg out_we_o,
    output reg [7:0] cfg_addr_o,
    output reg [7:0] cfg_wdata_o,
    output reg cfg_we_o,
    output reg [2:0] flags_o,
    output reg [7:0] ssp_low_o,
    output reg [7:0] usp_low_o
);
    localparam ST_IDLE = 3'd0;
    localparam ST_MEM1 = 3'd1;
    localparam ST_MEM2 = 3'd2;
    localparam ST_WAIT = 3'd3;
    localparam ST_DONE = 3'd4;

    // ==========================================
    // region decode, used for memory-to-output and memory-to-config reads only
    function [2:0] region_of;
        input [15:0] a;
        begin
            if (a <= `SAS_RESET_VEC_END) region_of = `SAS_RG_RESET;
            else if (a <= `SAS_IRQ_VEC_END) region_of = `SAS_RG_VECTOR;
            else if (a < NVM_SIZE) region_of = `SAS_RG_NVM;
            else if (a >= `SAS_OPT_BASE && a <= `SAS_OPT_END) region_of = `SAS_RG_OPTION;
            else if (a[15:8] >= `SAS_PAGE_FIXED) region_of = `SAS_RG_RAM;
            else region_of = `SAS_RG_NONE;
        end
    endfunction

    // one RAM page; any page at or above 32 outside the option bytes decodes as RAM, but only stack accesses fold onto it
    function [15:0] ram_addr;
        input [7:0] low;
        begin
            ram_addr = {`SAS_PAGE_FIXED, low};
        end
    endfunction

    // ==========================================
    // storage
    reg [7:0] rf_q [0:255];
    reg [2:0] fstk_q [0:FLAG_DEPTH-1];
    reg [FLAG_PTR_W-1:0] fptr_q;
    reg [7:0] ust_page_q, ust_low_q;
    reg [7:0] ssp_q, usp_q;
    reg [2:0] flags_q;
    reg [2:0] st_q;
    reg [3:0] op_q;
    reg [7:0] dst_q, src_q;
    reg [7:0] hi_q;
    reg [3:0] wcnt_q;
    reg [15:0] ret_pc_q;

    // ==========================================
    // config read mux
    reg [7:0] cfg_rd;
    always @* begin
        case (op_src_i)
            `SAS_CF_UST_PAGE: cfg_rd = ust_page_q;
            `SAS_CF_UST_LOW: cfg_rd = ust_low_q;
            `SAS_CF_SSP_PAGE: cfg_rd = `SAS_PAGE_FIXED;
            `SAS_CF_SSP_LOW: cfg_rd = ssp_q;
            default: cfg_rd = 8'h00;
        endcase
    end

    // input space: own registers answered locally, rest from peripherals
    reg [7:0] in_rd;
    always @* begin
        case (op_src_i)
            `SAS_IN_USP_PAGE: in_rd = `SAS_PAGE_FIXED;
            `SAS_IN_USP_LOW: in_rd = usp_q;
            `SAS_IN_FLAGS: in_rd = {5'b0_0000, flags_q};
            default: in_rd = in_rdata_i;
        endcase
    end

    wire is_mem_op = (op_code_i == `SAS_OP_MEM_TO_OUT) || (op_code_i == `SAS_OP_MEM_TO_CFG);
    wire [15:0] pop_pc = {hi_q, mem_rdata_i};
    wire imm_src = (op_code_i == `SAS_OP_IMM_TO_OUT) ||
        (op_code_i == `SAS_OP_IMM_TO_CFG);
    wire [7:0] imm_or_rf = imm_src ? op_imm_i : rf_q[op_src_i];
    wire [15:0] mem_a = {rf_q[op_src_i], op_imm_i};
    wire [2:0] mem_rg = region_of(mem_a);
    wire [3:0] mem_wt = (mem_rg == `SAS_RG_RAM) ?
        4'h0 : NVM_WAIT[3:0];

    // ==========================================
    // register file writes
    genvar gi;
    generate
        for (gi = 0; gi < 256; gi = gi + 1) begin : g_rf
            always @(posedge clk_sys_i or posedge rst_i) begin
                if (rst_i) begin
                    rf_q[gi] <= 8'h00;
                end else if (op_valid_i && st_q == ST_IDLE && op_dst_i == gi) begin
                    if (op_code_i == `SAS_OP_RR_MOVE) rf_q[gi] <= rf_q[op_src_i];
                    else if (op_code_i == `SAS_OP_IN_TO_REG) rf_q[gi] <= in_rd;
                    else if (op_code_i == `SAS_OP_CFG_TO_REG) rf_q[gi] <= cfg_rd;
                end else if (st_q == ST_MEM1 && op_q == `SAS_OP_POP && dst_q == gi) begin
                    rf_q[gi] <= mem_rdata_i;
                end
            end
        end
    endgenerate

    // ==========================================
    // sequencer
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            op_q <= `SAS_OP_NOP;
            dst_q <= 8'h00;
            src_q <= 8'h00;
            hi_q <= 8'h00;
            wcnt_q <= 4'h0;
            ret_pc_q <= 16'h0000;
            fptr_q <= {FLAG_PTR_W{1'b0}};
            ust_page_q <= `SAS_PAGE_FIXED;
            ust_low_q <= `SAS_USP_LOW_RST;
            ssp_q <= `SAS_SSP_LOW_RST;
            usp_q <= `SAS_USP_LOW_RST;
            flags_q <= `SAS_FLAGS_RST;
            op_done_o <= 1'b0;
            pc_load_o <= 16'h0000;
            pc_load_valid_o <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_wdata_o <= 8'h00;
            mem_we_o <= 1'b0;
            mem_re_o <= 1'b0;
            mem_region_o <= `SAS_RG_RESET;
            mem_wait_o <= 4'h0;
            opt_unimpl_o <= 1'b0;
            in_addr_o <= 8'h00;
            in_re_o <= 1'b0;
            out_addr_o <= 8'h00;
            out_wdata_o <= 8'h00;
            out_we_o <= 1'b0;
            cfg_addr_o <= 8'h00;
            cfg_wdata_o <= 8'h00;
            cfg_we_o <= 1'b0;
        end else begin
            op_done_o <= 1'b0;
            pc_load_valid_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_re_o <= 1'b0;
            in_re_o <= 1'b0;
            out_we_o <= 1'b0;
            cfg_we_o <= 1'b0;
            if (alu_flags_we_i) flags_q <= alu_flags_i;
            case (st_q)
                ST_IDLE: begin
                    if (op_valid_i) begin
                        op_q <= op_code_i;
                        dst_q <= op_dst_i;
                        src_q <= op_src_i;
                        mem_region_o <= `SAS_RG_RAM;
                        mem_wait_o <= 4'h0;
                        case (op_code_i)
                            `SAS_OP_RR_MOVE, `SAS_OP_CFG_TO_REG: begin
                                op_done_o <= 1'b1;
                            end
                            `SAS_OP_IN_TO_REG: begin
                                in_addr_o <= op_src_i;
                                in_re_o <= 1'b1;
                                op_done_o <= 1'b1;
                            end
                            `SAS_OP_IMM_TO_OUT, `SAS_OP_REG_TO_OUT: begin
                                out_addr_o <= op_dst_i;
                                out_wdata_o <= imm_or_rf;
                                out_we_o <= 1'b1;
                                op_done_o <= 1'b1;
                            end
                            `SAS_OP_IMM_TO_CFG, `SAS_OP_REG_TO_CFG: begin
                                cfg_addr_o <= op_dst_i;
                                cfg_wdata_o <= imm_or_rf;
                                cfg_we_o <= 1'b1;
                                op_done_o <= 1'b1;
                                if (op_dst_i == `SAS_CF_UST_PAGE) ust_page_q <= imm_or_rf;
                                if (op_dst_i == `SAS_CF_UST_LOW) begin
                                    ust_low_q <= imm_or_rf;
                                    usp_q <= imm_or_rf;
                                end
                                if (op_dst_i == `SAS_CF_SSP_LOW) begin
                                    ssp_q <= imm_or_rf;
                                end
                            end
                            `SAS_OP_CALL, `SAS_OP_IRQ: begin
                                // low byte of PC at ssp, high byte just below
                                mem_addr_o <= ram_addr(ssp_q);
                                mem_wdata_o <= pc_i[7:0];
                                mem_we_o <= 1'b1;
                                ret_pc_q <= pc_i;
                                st_q <= ST_MEM1;
                                if (op_code_i == `SAS_OP_IRQ) begin
                                    fstk_q[fptr_q] <= flags_q;
                                    fptr_q <= fptr_q + 1'b1;
                                end
                            end
                            `SAS_OP_RET, `SAS_OP_IRET: begin
                                ssp_q <= ssp_q + 8'h02;
                                mem_addr_o <= ram_addr(ssp_q + 8'h01);
                                mem_re_o <= 1'b1;
                                st_q <= ST_MEM1;
                                if (op_code_i == `SAS_OP_IRET) begin
                                    flags_q <= fstk_q[fptr_q - 1'b1];
                                    fptr_q <= fptr_q - 1'b1;
                                end
                            end
                            `SAS_OP_PUSH: begin
                                mem_addr_o <= ram_addr(usp_q);
                                mem_wdata_o <= rf_q[op_src_i];
                                mem_we_o <= 1'b1;
                                usp_q <= usp_q + 8'h01;
                                op_done_o <= 1'b1;
                            end
                            `SAS_OP_POP: begin
                                usp_q <= usp_q - 8'h01;
                                mem_addr_o <= ram_addr(usp_q - 8'h01);
                                mem_re_o <= 1'b1;
                                st_q <= ST_MEM1;
                            end
                            default: begin
                                if (is_mem_op) begin
                                    // high byte from the rf register named by src, low byte from imm
                                    mem_addr_o <= mem_a;
                                    mem_re_o <= 1'b1;
                                    mem_region_o <= mem_rg;
                                    opt_unimpl_o <= (mem_a > `SAS_OPT_LAST_IMPL) &&
                                        (mem_a <= `SAS_OPT_END);
                                    mem_wait_o <= mem_wt;
                                    wcnt_q <= mem_wt;
                                    st_q <= ST_WAIT;
                                end else begin
                                    op_done_o <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
                ST_MEM1: begin
                    if (op_q == `SAS_OP_CALL || op_q == `SAS_OP_IRQ) begin
                        mem_addr_o <= ram_addr(ssp_q - 8'h01);
                        mem_wdata_o <= ret_pc_q[15:8];
                        mem_we_o <= 1'b1;
                        ssp_q <= ssp_q - 8'h02;
                        op_done_o <= 1'b1;
                        st_q <= ST_IDLE;
                    end else if (op_q == `SAS_OP_POP) begin
                        op_done_o <= 1'b1;
                        st_q <= ST_IDLE;
                    end else begin
                        hi_q <= mem_rdata_i;
                        mem_addr_o <= ram_addr(ssp_q);
                        mem_re_o <= 1'b1;
                        st_q <= ST_MEM2;
                    end
                end
                ST_MEM2: begin
                    pc_load_o <= pop_pc;
                    pc_load_valid_o <= 1'b1;
                    op_done_o <= 1'b1;
                    st_q <= ST_IDLE;
                end
                ST_WAIT: begin
                    // nvm needs extra cycles before data is stable
                    if (wcnt_q == 4'h0) st_q <= ST_DONE;
                    else wcnt_q <= wcnt_q - 4'h1;
                end
                ST_DONE: begin
                    if (op_q == `SAS_OP_MEM_TO_OUT) begin
                        out_addr_o <= dst_q;
                        out_wdata_o <= mem_rdata_i;
                        out_we_o <= 1'b1;
                    end else begin
                        cfg_addr_o <= dst_q;
                        cfg_wdata_o <= mem_rdata_i;
                        cfg_we_o <= 1'b1;
                        // a table load into a pointer register moves the pointer too
                        if (dst_q == `SAS_CF_UST_PAGE) ust_page_q <= mem_rdata_i;
                        if (dst_q == `SAS_CF_UST_LOW) begin
                            ust_low_q <= mem_rdata_i;
                            usp_q <= mem_rdata_i;
                        end
                        if (dst_q == `SAS_CF_SSP_LOW) ssp_q <= mem_rdata_i;
                    end
                    op_done_o <= 1'b1;
                    st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // status outputs
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            flags_o <= `SAS_FLAGS_RST;
            ssp_low_o <= `SAS_SSP_LOW_RST;
            usp_low_o <= `SAS_USP_LOW_RST;
        end else begin
            flags_o <= flags_q;
            ssp_low_o <= ssp_q;
            usp_low_o <= usp_q;
        end
    end
endmodule // sas_core
`default_nettype wire

// >>> core/sas_defs.vh
// constants for the stack and address-space block
// Operation
// - flags read-only, reset zero, Z S C
// - load op names source and destination space
// - decode memory type, set access timing
// - 256 byte register file, moves copy
// - 256 byte RAM bank after nonvolatile memory
// - addresses 0..2 hold reset vector
// - addresses 3..32 hold interrupt vectors
// - membership block ends by address 1023
// - option bytes 3000h..307Fh, eight implemented
// - call stores PC, system pointer minus two
// - return adds two, reloads PC
// - interrupt saves flags on flag stack
// - system pointer config at 2Ch, 2Dh
// - system pointer low resets to 255
// - user pointer low resets to zero
// - push writes then increments; pop reverse
// - writing user stack top loads pointer
// - user pointer readable at input 0Bh, 0Ch
// - input registers read-only via load
// - output registers write-only from sources
// - config registers read and write same address; core reads back only 05h, 06h, 2Dh, gives fixed 20h at 2Ch and zero elsewhere
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH
// ==========================================
// register offsets
`define SAS_IN_USP_PAGE 8'h0b
`define SAS_IN_USP_LOW 8'h0c
`define SAS_IN_FLAGS 8'h26
`define SAS_CF_UST_PAGE 8'h05
`define SAS_CF_UST_LOW 8'h06
`define SAS_CF_SSP_PAGE 8'h2c
`define SAS_CF_SSP_LOW 8'h2d
// ==========================================
// reset values
`define SAS_PAGE_FIXED 8'h20
`define SAS_SSP_LOW_RST 8'hff
`define SAS_USP_LOW_RST 8'h00
`define SAS_FLAGS_RST 3'h0
// ==========================================
// memory map
`define SAS_RESET_VEC_END 16'h0002
`define SAS_IRQ_VEC_END 16'h0020
`define SAS_MBF_LAST 16'h03ff
`define SAS_OPT_BASE 16'h3000
`define SAS_OPT_LAST_IMPL 16'h3007
`define SAS_OPT_END 16'h307f
// ==========================================
// operation codes
`define SAS_OP_NOP 4'h0
`define SAS_OP_RR_MOVE 4'h1
`define SAS_OP_IN_TO_REG 4'h2
`define SAS_OP_IMM_TO_OUT 4'h3
`define SAS_OP_REG_TO_OUT 4'h4
`define SAS_OP_MEM_TO_OUT 4'h5
`define SAS_OP_IMM_TO_CFG 4'h6
`define SAS_OP_REG_TO_CFG 4'h7
`define SAS_OP_MEM_TO_CFG 4'h8
`define SAS_OP_CFG_TO_REG 4'h9
`define SAS_OP_CALL 4'ha
`define SAS_OP_IRQ 4'hb
`define SAS_OP_RET 4'hc
`define SAS_OP_IRET 4'hd
`define SAS_OP_PUSH 4'he
`define SAS_OP_POP 4'hf
// ==========================================
// memory region codes
`define SAS_RG_RESET 3'h0
`define SAS_RG_VECTOR 3'h1
`define SAS_RG_NVM 3'h2
`define SAS_RG_RAM 3'h3
`define SAS_RG_OPTION 3'h4
`define SAS_RG_NONE 3'h5
`endif

// >>> sim/sas_core_checker.sv
// assertions on the ports of the stack and address-space core
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.vh"
module sas_core_checker #(
    parameter NVM_WAIT = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire logic [3:0] op_code_i,
    input wire logic [15:0] pc_i,
    input wire logic op_done_o,
    input wire logic pc_load_valid_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic mem_we_o,
    input wire logic mem_re_o,
    input wire logic [2:0] mem_region_o,
    input wire logic [3:0] mem_wait_o,
    input wire logic opt_unimpl_o,
    input wire logic [7:0] cfg_addr_o,
    input wire logic [7:0] cfg_wdata_o,
    input wire logic cfg_we_o,
    input wire logic [7:0] ssp_low_o,
    input wire logic [7:0] usp_low_o
);
    // ==========================================
    // acceptance tracking
    logic busy_q;
    wire take = op_valid_i && !busy_q;
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
        end else if (take) begin
            busy_q <= 1'b1;
        end else if (op_done_o) begin
            busy_q <= 1'b0;
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_store_pc;
        mem_we_o && mem_wdata_o == $past(pc_i[7:0])
        ##1 mem_we_o && op_done_o && mem_wdata_o == $past(pc_i[15:8], 2);
    endsequence
    sequence s_reload_pc;
        mem_re_o ##1 mem_re_o ##1 pc_load_valid_o && op_done_o;
    endsequence
    call_store_a: assert property (take && (op_code_i == `SAS_OP_CALL ||
        op_code_i == `SAS_OP_IRQ) |=> s_store_pc) else $error("call store wrong");
    ret_reload_a: assert property (take && (op_code_i == `SAS_OP_RET ||
        op_code_i == `SAS_OP_IRET) |=> s_reload_pc) else $error("return reload wrong");
    ssp_down_a: assert property (take && op_code_i == `SAS_OP_CALL
        |-> ##4 ssp_low_o == $past(ssp_low_o, 4) - 8'h02) else $error("ssp not lowered");
    push_write_a: assert property (take && op_code_i == `SAS_OP_PUSH |=> mem_we_o
        && mem_addr_o == {8'h20, $past(usp_low_o)} && op_done_o) else $error("push wrong");
    pop_read_a: assert property (take && op_code_i == `SAS_OP_POP |=> mem_re_o
        && mem_addr_o == {8'h20, $past(usp_low_o) - 8'h01} ##1 op_done_o) else $error("pop wrong");
    wait_match_a: assert property (mem_re_o && mem_region_o != `SAS_RG_NONE
        |-> mem_wait_o == ((mem_region_o == `SAS_RG_RAM) ? 4'h0 : 4'(NVM_WAIT)))
        else $error("wait mismatch");
    vector_region_a: assert property (mem_re_o && mem_addr_o >= 16'h0003
        && mem_addr_o <= 16'h0020 |-> mem_region_o == `SAS_RG_VECTOR) else $error("vector");
    option_flag_a: assert property (mem_re_o && mem_addr_o >= 16'h3000
        && mem_addr_o <= 16'h307f |-> mem_region_o == `SAS_RG_OPTION
        && opt_unimpl_o == (mem_addr_o > 16'h3007)) else $error("option flag wrong");
    ust_copy_a: assert property (cfg_we_o && cfg_addr_o == 8'h06
        |-> ##2 usp_low_o == $past(cfg_wdata_o, 2)) else $error("usp not copied");
    ssp_write_a: assert property (cfg_we_o && cfg_addr_o == 8'h2d
        |-> ##2 ssp_low_o == $past(cfg_wdata_o, 2)) else $error("ssp not written");
endmodule // sas_core_checker

bind sas_core sas_core_checker #(.NVM_WAIT(NVM_WAIT)) i_chk (.clk_sys_i, .rst_i, .op_valid_i,
    .op_code_i, .pc_i, .op_done_o, .pc_load_valid_o, .mem_addr_o, .mem_wdata_o, .mem_we_o,
    .mem_re_o, .mem_region_o, .mem_wait_o, .opt_unimpl_o, .cfg_addr_o, .cfg_wdata_o,
    .cfg_we_o, .ssp_low_o, .usp_low_o);
`default_nettype wire

// >>> sim/sas_mem_model.sv
// program/data memory and input-register model facing the core
`timescale 1ns/1ps
`default_nettype none
module sas_mem_model (
    input wire logic clk_sys_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    input wire logic mem_we_i,
    input wire logic [7:0] op_src_i,
    output logic [7:0] rdata_o,
    output logic [7:0] in_data_o
);
    logic [7:0] mem [0:65535];
    integer i;
    initial begin
        for (i = 0; i < 65536; i = i + 1) mem[i] = i[7:0] ^ i[15:8] ^ 8'h77;
    end
    always @(posedge clk_sys_i) begin
        if (mem_we_i) mem[mem_addr_i] <= mem_wdata_i;
    end
    // the core samples in the cycle its address stands and holds it through waits
    assign rdata_o = mem[mem_addr_i];
    // no write path: peripherals own these values
    assign in_data_o = ~op_src_i;
endmodule // sas_mem_model
`default_nettype wire

// >>> sim/stack_and_address_spaces_test.sv
// self-checking bench for the stack and address-space core
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.vh"
`define CHK(got, exp, msg) begin \
    checks = checks + 1; \
    if ((got) !== (exp)) begin \
        errors = errors + 1; \
        $display("CHECK FAILED at %0t: %s", $time, msg); \
    end \
end
module stack_and_address_spaces_test;
    localparam int NW = 3;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic op_valid_i = 1'b0;
    logic alu_flags_we_i = 1'b0;
    logic [3:0] op_code_i = 4'h0;
    logic [7:0] op_dst_i = 8'h00, op_src_i = 8'h00, op_imm_i = 8'h00;
    logic [15:0] pc_i = 16'h0000;
    logic [2:0] alu_flags_i = 3'h0;
    logic [7:0] mem_rdata_i, in_rdata_i, mem_wdata_o, in_addr_o, out_addr_o, out_wdata_o;
    logic [7:0] cfg_addr_o, cfg_wdata_o, ssp_low_o, usp_low_o, out_a, out_d, cfg_d;
    logic [15:0] pc_load_o, mem_addr_o, pcl, a;
    logic [2:0] mem_region_o, flags_o, rg;
    logic [3:0] mem_wait_o, wt;
    logic op_done_o, pc_load_valid_o, mem_we_o, mem_re_o, opt_unimpl_o, in_re_o;
    logic out_we_o, cfg_we_o, un;
    logic [15:0] ma [6] = '{16'h0001, 16'h0010, 16'h0100, 16'h2005, 16'h3003, 16'h3050};
    logic [2:0] mr [6] = '{`SAS_RG_RESET, `SAS_RG_VECTOR, `SAS_RG_NVM, `SAS_RG_RAM,
        `SAS_RG_OPTION, `SAS_RG_OPTION};
    int errors = 0;
    int checks = 0;
    sas_core #(.NVM_WAIT(NW)) i_dut (.clk_sys_i, .rst_i, .op_valid_i, .op_code_i, .op_dst_i,
        .op_src_i, .op_imm_i, .pc_i, .alu_flags_i, .alu_flags_we_i, .mem_rdata_i, .in_rdata_i,
        .op_done_o, .pc_load_o, .pc_load_valid_o, .mem_addr_o, .mem_wdata_o, .mem_we_o,
        .mem_re_o, .mem_region_o, .mem_wait_o, .opt_unimpl_o, .in_addr_o, .in_re_o,
        .out_addr_o, .out_wdata_o, .out_we_o, .cfg_addr_o, .cfg_wdata_o, .cfg_we_o,
        .flags_o, .ssp_low_o, .usp_low_o);
    sas_mem_model i_mem (.clk_sys_i, .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_we_i(mem_we_o), .op_src_i, .rdata_o(mem_rdata_i), .in_data_o(in_rdata_i));
    always #2.5 clk_sys_i = ~clk_sys_i;
    // ==========================================
    // strobe capture
    always @(posedge clk_sys_i) begin
        if (out_we_o) begin
            out_a <= out_addr_o;
            out_d <= out_wdata_o;
        end
        if (cfg_we_o) cfg_d <= cfg_wdata_o;
        if (pc_load_valid_o) pcl <= pc_load_o;
        if (mem_re_o) begin
            rg <= mem_region_o;
            wt <= mem_wait_o;
            un <= opt_unimpl_o;
        end
    end
    // ==========================================
    // access tasks
    task automatic op(input logic [3:0] c, input logic [7:0] d, s, m,
        input logic [15:0] p = 16'h0000);
        @(posedge clk_sys_i);
        op_code_i <= c;
        op_dst_i <= d;
        op_src_i <= s;
        op_imm_i <= m;
        pc_i <= p;
        op_valid_i <= 1'b1;
        fork
            @(posedge op_done_o);
            begin
                repeat (40) @(posedge clk_sys_i);
                errors++;
                $display("CHECK FAILED at %0t: no completion", $time);
            end
        join_any
        disable fork;
        op_valid_i <= 1'b0;
        // mirrors trail by a cycle
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic show(input logic [7:0] r, input logic [7:0] e);
        op(`SAS_OP_REG_TO_OUT, 8'h07, r, 8'h00);
        `CHK({out_a, out_d}, {8'h07, e}, "register through output")
    endtask
    task automatic inreg(input logic [7:0] s, input logic [7:0] e);
        op(`SAS_OP_IN_TO_REG, 8'h12, s, 8'h00);
        show(8'h12, e);
    endtask
    task automatic flag(input logic [2:0] v);
        @(posedge clk_sys_i);
        alu_flags_i <= v;
        alu_flags_we_i <= 1'b1;
        @(posedge clk_sys_i);
        alu_flags_we_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #50000;
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict();
    end
    // ==========================================
    // tests
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        `CHK({ssp_low_o, usp_low_o}, 16'hff00, "pointer reset")
        `CHK(flags_o, 3'h0, "flags reset")
        $display("test reset done");
        op(`SAS_OP_IMM_TO_CFG, 8'h05, 8'h00, 8'hff);
        op(`SAS_OP_IMM_TO_CFG, 8'h06, 8'h00, 8'hfe);
        `CHK({cfg_d, usp_low_o}, 16'hfefe, "user stack top copy")
        op(`SAS_OP_IN_TO_REG, 8'h10, 8'h01, 8'h00);
        op(`SAS_OP_IN_TO_REG, 8'h11, 8'h02, 8'h00);
        op(`SAS_OP_RR_MOVE, 8'h14, 8'h11, 8'h00);
        show(8'h14, 8'hfd);
        op(`SAS_OP_IMM_TO_OUT, 8'h0e, 8'h00, 8'ha5);
        `CHK({out_a, out_d}, 16'h0ea5, "immediate output")
        inreg(8'h0c, 8'hfe);
        inreg(8'h0b, 8'h20);
        $display("test spaces done");
        op(`SAS_OP_PUSH, 8'h10, 8'h10, 8'h00);
        op(`SAS_OP_PUSH, 8'h14, 8'h14, 8'h00);
        `CHK({i_mem.mem[16'h20fe], i_mem.mem[16'h20ff]}, 16'hfefd, "push data")
        `CHK(usp_low_o, 8'h00, "user pointer wrap")
        op(`SAS_OP_POP, 8'h13, 8'h13, 8'h00);
        `CHK(usp_low_o, 8'hff, "user pointer after pop")
        show(8'h13, 8'hfd);
        $display("test user stack done");
        op(`SAS_OP_CALL, 8'h00, 8'h00, 8'h00, 16'h1234);
        op(`SAS_OP_CALL, 8'h00, 8'h00, 8'h00, 16'habcd);
        `CHK({i_mem.mem[16'h20fc], i_mem.mem[16'h20fd], i_mem.mem[16'h20fe],
            i_mem.mem[16'h20ff], ssp_low_o}, 40'hab_cd12_34fb, "call frames")
        op(`SAS_OP_RET, 8'h00, 8'h00, 8'h00);
        `CHK({pcl, ssp_low_o}, 24'hab_cdfd, "first return")
        op(`SAS_OP_RET, 8'h00, 8'h00, 8'h00);
        `CHK({pcl, ssp_low_o}, 24'h12_34ff, "second return")
        op(`SAS_OP_IMM_TO_CFG, 8'h2d, 8'h00, 8'h01);
        op(`SAS_OP_CFG_TO_REG, 8'h16, 8'h2d, 8'h00);
        show(8'h16, 8'h01);
        op(`SAS_OP_CFG_TO_REG, 8'h16, 8'h2c, 8'h00);
        show(8'h16, 8'h20);
        op(`SAS_OP_CALL, 8'h00, 8'h00, 8'h00, 16'h5aa5);
        `CHK({i_mem.mem[16'h2000], i_mem.mem[16'h2001], ssp_low_o}, 24'h5a_a5ff, "wrap")
        op(`SAS_OP_RET, 8'h00, 8'h00, 8'h00);
        `CHK({pcl, ssp_low_o}, 24'h5a_a501, "wrap return")
        op(`SAS_OP_REG_TO_CFG, 8'h2d, 8'h10, 8'h00);
        `CHK(ssp_low_o, 8'hfe, "pointer from register")
        $display("test system stack done");
        flag(3'h5);
        inreg(8'h26, 8'h05);
        op(`SAS_OP_IRQ, 8'h00, 8'h00, 8'h00, 16'h0f00);
        flag(3'h2);
        `CHK(flags_o, 3'h2, "flags in handler")
        op(`SAS_OP_IRET, 8'h00, 8'h00, 8'h00);
        `CHK({pcl, 5'h00, flags_o}, 24'h0f_0005, "flags restored")
        $display("test flags done");
        for (int k = 0; k < 6; k++) begin
            a = ma[k];
            op(`SAS_OP_IN_TO_REG, 8'h20, ~a[15:8], 8'h00);
            op(`SAS_OP_MEM_TO_OUT, 8'h07, 8'h20, a[7:0]);
            `CHK(out_d, a[7:0] ^ a[15:8] ^ 8'h77, "memory data")
            `CHK(rg, mr[k], "region")
            `CHK(wt, (mr[k] == `SAS_RG_RAM) ? 4'h0 : 4'(NW), "wait")
            `CHK(un, a > 16'h3007, "option implemented")
        end
        op(`SAS_OP_MEM_TO_CFG, 8'h06, 8'h20, 8'h50);
        `CHK({cfg_d, usp_low_o}, {2{8'h50 ^ 8'h30 ^ 8'h77}}, "memory to config")
        $display("test memory map done");
        print_verdict();
    end
endmodule // stack_and_address_spaces_test
`default_nettype wire
